/* File: pkg/sas_consts.vh */
// Purpose: Constants of the converter control and channel sequencer.
// Assumes: pclk at 100 MHz, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses except the two bases, which match paddr[7:5]; each register one aligned word.
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH

// Clock figures and converter timing
`define SAS_PCLK_MHZ        100
`define SAS_CONV_MAX_MHZ    18
`define SAS_CONV_DIV        ((`SAS_PCLK_MHZ + `SAS_CONV_MAX_MHZ - 1) / `SAS_CONV_MAX_MHZ)
`define SAS_CONV_CLKS       18
`define SAS_RES_BITS        12
`define SAS_NUM_CH          8

// Register offsets
`define SAS_OFS_CTRL        8'h00
`define SAS_OFS_CHAN_EN     8'h04
`define SAS_OFS_STATUS      8'h08
`define SAS_OFS_MASK        8'h0C
`define SAS_OFS_RANGE_LO    8'h10
`define SAS_OFS_RANGE_HI    8'h14
`define SAS_OFS_STATE       8'h18
`define SAS_OFS_SMP_BASE    3'h1
`define SAS_OFS_RES_BASE    3'h2

// Control fields
`define SAS_CTRL_ENABLE     0
`define SAS_CTRL_CONT       1
`define SAS_CTRL_FW_MODE    2
`define SAS_CTRL_START      3
`define SAS_CTRL_MCH_LO     4

// Status and mask fields
`define SAS_ST_DONE         0
`define SAS_ST_RANGE        1

// Reset values
`define SAS_RST_CTRL        7'h00
`define SAS_RST_CHAN_EN     8'hFF
`define SAS_RST_RANGE_LO    12'h000
`define SAS_RST_RANGE_HI    12'hFFF
`define SAS_RST_SMP         8'h03
`define SAS_RST_MASK        2'h0

`endif

/* File: rtl/sas_sync3.v */
// Purpose: Three-stage synchroniser for one asynchronous level.
// Assumes: The level may change at any time relative to pclk.
// Notes:   The output moves only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module sas_sync3 (
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output reg  sync_out
);

    reg s1;
    reg s2;
    reg s3;

    // Shift chain and agreement filter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1       <= 1'b0;
            s2       <= 1'b0;
            s3       <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_out <= s3;
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/sas_sequencer.v */
// Purpose: SAR converter control, eight-channel sequencer, APB registers.
// Assumes: Analog comparator output high while input >= trial DAC code.
// Notes:   Converter clock is a one-cycle enable at pclk / 6.
// How it works
// - Converter tick at most 18 MHz, 18 clocks
// - Sample window length is programmable
// - Sequencer selects one of eight inputs
// - Scan steps channels back to back
// - State machine or firmware picks the channel
// - Per-channel result buffer held until read (here a new store to the channel overwrites it, read or not)
// - Each channel has its own sample time
// - Result outside low/high limits raises interrupt
// - Range event raised at conversion end
// - Halted while deep low-power mode holds
//
// Added by the designer: register access over APB and the register offsets.
`include "sas_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module sas_sequencer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq,
    input  wire        deep_sleep,
    input  wire        ana_cmp,
    output reg  [2:0]  ana_chan,
    output wire        ana_sample,
    output reg  [11:0] ana_dac
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SAMP = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;
    localparam integer DIV_LAST_I  = `SAS_CONV_DIV - 1;
    localparam integer CONV_LAST_I = `SAS_CONV_CLKS - 1;
    localparam [2:0] DIV_LAST  = DIV_LAST_I[2:0];
    localparam [7:0] CONV_LAST = CONV_LAST_I[7:0];

    reg  [6:0]  ctrl;
    reg  [7:0]  chan_en;
    reg  [1:0]  status;
    reg  [1:0]  mask;
    reg  [11:0] range_lo;
    reg  [11:0] range_hi;
    reg  [7:0]  smp_time [0:7];
    reg  [11:0] res_mem [0:7];
    reg  [7:0]  res_valid;
    reg  [2:0]  range_ch;
    reg  [1:0]  state;
    reg  [7:0]  cnt;
    reg  [2:0]  cur_ch;
    reg  [11:0] trial;
    reg  [2:0]  div_cnt;
    reg         tick;
    reg  [31:0] rd_data;
    reg         rd_ok;
    reg         nxt_found;
    reg  [2:0]  nxt_ch;
    reg         first_found;
    reg  [2:0]  first_ch;
    reg  [7:0]  smp_len;
    reg         ev_done;
    reg         ev_range;
    reg         ev_store;
    reg  [2:0]  rd_clr_ch;
    wire        cmp_s;
    wire        sleep_s;
    wire        setup;
    wire        access;
    wire        wr_acc;
    wire        rd_acc;
    wire        start;
    wire        run_ok;
    integer     i;
    integer     j;
    integer     k;

    sas_sync3 u_sync_cmp (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ana_cmp),
        .sync_out (cmp_s)
    );

    sas_sync3 u_sync_sleep (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (deep_sleep),
        .sync_out (sleep_s)
    );

    // APB phases; answer in the first access cycle
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wr_acc  = access & pwrite & rd_ok;
    assign rd_acc  = access & ~pwrite & rd_ok;
    assign pready  = 1'b1;
    assign pslverr = access & ~rd_ok;
    assign start   = wr_acc & (paddr == `SAS_OFS_CTRL) & pwdata[`SAS_CTRL_START];
    assign run_ok  = ctrl[`SAS_CTRL_ENABLE] & ~sleep_s;
    assign ana_sample = state[0];
    assign irq     = |(status & mask);

    // Lowest enabled channel, and lowest enabled above the current one
    always @* begin
        nxt_found   = 1'b0;
        nxt_ch      = 3'h0;
        first_found = 1'b0;
        first_ch    = 3'h0;
        for (i = `SAS_NUM_CH - 1; i >= 0; i = i - 1) begin
            if (chan_en[i]) begin
                first_found = 1'b1;
                first_ch    = i[2:0];
                if (i > cur_ch) begin
                    nxt_found = 1'b1;
                    nxt_ch    = i[2:0];
                end
            end
        end
        smp_len = (smp_time[cur_ch] == 8'h00) ? 8'h01 : smp_time[cur_ch];
    end

    // Address decode and read data
    always @* begin
        rd_data   = 32'h0000_0000;
        rd_ok     = 1'b1;
        rd_clr_ch = paddr[4:2];
        if (paddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (paddr[7:5] == `SAS_OFS_SMP_BASE) begin
            rd_data = {24'h00_0000, smp_time[paddr[4:2]]};
        end else if (paddr[7:5] == `SAS_OFS_RES_BASE) begin
            rd_data = {res_valid[paddr[4:2]], 19'h0_0000, res_mem[paddr[4:2]]};
        end else begin
            case (paddr)
                `SAS_OFS_CTRL:     rd_data = {25'h000_0000, ctrl};
                `SAS_OFS_CHAN_EN:  rd_data = {24'h00_0000, chan_en};
                `SAS_OFS_STATUS:   rd_data = {27'h000_0000, range_ch, status};
                `SAS_OFS_MASK:     rd_data = {30'h0000_0000, mask};
                `SAS_OFS_RANGE_LO: rd_data = {20'h0_0000, range_lo};
                `SAS_OFS_RANGE_HI: rd_data = {20'h0_0000, range_hi};
                `SAS_OFS_STATE:    rd_data = {24'h00_0000, sleep_s, cur_ch, 2'h0, state};
                default:           rd_ok = 1'b0;
            endcase
        end
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata <= rd_data;
        end
    end

    // Converter clock enable; restarted on a start so the first window is whole
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
            tick    <= 1'b0;
        end else if (!run_ok || (start && (state == ST_IDLE))) begin
            div_cnt <= 3'h0;
            tick    <= 1'b0;
        end else begin
            tick    <= (div_cnt == DIV_LAST);
            div_cnt <= (div_cnt == DIV_LAST) ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // Software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `SAS_RST_CTRL;
            chan_en  <= `SAS_RST_CHAN_EN;
            mask     <= `SAS_RST_MASK;
            range_lo <= `SAS_RST_RANGE_LO;
            range_hi <= `SAS_RST_RANGE_HI;
            for (j = 0; j < `SAS_NUM_CH; j = j + 1) begin
                smp_time[j] <= `SAS_RST_SMP;
            end
        end else if (wr_acc) begin
            if (paddr[7:5] == `SAS_OFS_SMP_BASE) begin
                smp_time[paddr[4:2]] <= pwdata[7:0];
            end
            case (paddr)
                `SAS_OFS_CTRL:     ctrl <= {pwdata[6:4], 1'b0, pwdata[2:0]};
                `SAS_OFS_CHAN_EN:  chan_en <= pwdata[7:0];
                `SAS_OFS_MASK:     mask <= pwdata[1:0];
                `SAS_OFS_RANGE_LO: range_lo <= pwdata[11:0];
                `SAS_OFS_RANGE_HI: range_hi <= pwdata[11:0];
                default:           ;
            endcase
        end
    end

    // Sticky status, write one to clear, new event wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status   <= 2'h0;
            range_ch <= 3'h0;
        end else begin
            if (wr_acc && paddr == `SAS_OFS_STATUS) begin
                status <= (status & ~pwdata[1:0]) | {ev_range, ev_done};
            end else begin
                status <= status | {ev_range, ev_done};
            end
            if (ev_range) begin
                range_ch <= cur_ch;
            end
        end
    end

    // Result buffers; valid clears on read, a new store wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 8'h00;
            for (k = 0; k < `SAS_NUM_CH; k = k + 1) begin
                res_mem[k] <= 12'h000;
            end
        end else begin
            if (rd_acc && paddr[7:5] == `SAS_OFS_RES_BASE) begin
                res_valid[rd_clr_ch] <= 1'b0;
            end
            if (ev_store) begin
                res_mem[cur_ch]   <= ana_dac;
                res_valid[cur_ch] <= 1'b1;
            end
        end
    end

    // Conversion end events
    always @* begin
        ev_store = (state == ST_CONV) && tick && (cnt == CONV_LAST);
        ev_range = ev_store && ((ana_dac < range_lo) || (ana_dac > range_hi));
        ev_done  = ev_store && !ctrl[`SAS_CTRL_FW_MODE] && !nxt_found;
    end

    // Sequencer and successive approximation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_IDLE;
            cnt      <= 8'h00;
            cur_ch   <= 3'h0;
            ana_chan <= 3'h0;
            ana_dac  <= 12'h000;
            trial    <= 12'h000;
        end else if (!run_ok) begin
            state <= ST_IDLE;
            cnt   <= 8'h00;
            trial <= 12'h000;
        end else begin
            case (state)
                ST_IDLE: begin
                    cnt <= 8'h00;
                    if (start && ctrl[`SAS_CTRL_FW_MODE]) begin
                        cur_ch   <= ctrl[6:4];
                        ana_chan <= ctrl[6:4];
                        state    <= ST_SAMP;
                    end else if (start && first_found) begin
                        cur_ch   <= first_ch;
                        ana_chan <= first_ch;
                        state    <= ST_SAMP;
                    end
                end
                ST_SAMP: begin
                    if (tick) begin
                        if (cnt + 8'h01 >= smp_len) begin
                            state   <= ST_CONV;
                            cnt     <= 8'h00;
                            ana_dac <= 12'h800;
                            trial   <= 12'h800;
                        end else begin
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        if (trial != 12'h000) begin
                            ana_dac <= (cmp_s ? ana_dac : (ana_dac & ~trial)) | (trial >> 1);
                            trial   <= trial >> 1;
                        end
                        if (cnt == CONV_LAST) begin
                            cnt <= 8'h00;
                            if (ctrl[`SAS_CTRL_FW_MODE]) begin
                                state <= ST_IDLE;
                            end else if (nxt_found) begin
                                cur_ch   <= nxt_ch;
                                ana_chan <= nxt_ch;
                                state    <= ST_SAMP;
                            end else if (ctrl[`SAS_CTRL_CONT] && first_found) begin
                                cur_ch   <= first_ch;
                                ana_chan <= first_ch;
                                state    <= ST_SAMP;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: sim/sas_seq_properties.sv */
// Purpose: Port assertions for the converter sequencer.
// Assumes: Converter tick every 6 pclk, pready tied high.
// Notes:   Bound to every sas_sequencer instance.
`timescale 1ns/100ps
`default_nettype none
module sas_seq_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        deep_sleep,
    input wire logic [2:0]  ana_chan,
    input wire logic        ana_sample,
    input wire logic [11:0] ana_dac
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] gap;
    logic       seen;
    // Cycles since the last sample window closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (ana_sample) begin
            gap <= 8'h00;
            seen <= 1'b1;
        end else if (gap != 8'hFF) begin
            gap <= gap + 8'h01;
        end
    end
    sequence s_open;
        $rose(ana_sample);
    endsequence
    sequence s_hold;
        ana_sample [*5];
    endsequence
    chk_sample_min: assert property (s_open |=> s_hold)
        else $error("sample window shorter than one tick");
    chk_conv_length: assert property ($rose(ana_sample) && seen |-> gap >= 8'h6C)
        else $error("conversion shorter than 18 ticks");
    chk_dac_spacing: assert property ($changed(ana_dac) |=> $stable(ana_dac) [*5])
        else $error("trial code faster than converter tick");
    chk_dac_converting: assert property ($changed(ana_dac) |-> !ana_sample)
        else $error("trial code moved while sampling");
    chk_dac_msb: assert property ($fell(ana_sample) |-> ##[0:2] ana_dac == 12'h800)
        else $error("conversion did not start at mid code");
    chk_chan_steady: assert property (ana_sample && $past(ana_sample) |-> $stable(ana_chan))
        else $error("channel moved inside sample window");
    chk_sleep_idle: assert property (deep_sleep [*8] |-> !ana_sample)
        else $error("sampling while in deep sleep");
    chk_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved outside read setup");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access cycle");
    chk_ready_access: assert property (psel && penable |-> pready)
        else $error("access not answered");
endmodule
bind sas_sequencer sas_seq_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .deep_sleep, .ana_chan, .ana_sample, .ana_dac);
`default_nettype wire

/* File: sim/sas_analog_model.sv */
// Purpose: Eight fixed analog inputs and the trial comparator.
// Assumes: Each input level is a 12-bit code, steady during a run.
// Notes:   Comparator output is asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module sas_analog_model (
    input  wire logic [95:0] level,
    input  wire logic [2:0]  ana_chan,
    input  wire logic [11:0] ana_dac,
    output logic             ana_cmp
);
    // High while the selected input is at or above the trial code
    assign ana_cmp = (level[ana_chan*12 +: 12] >= ana_dac);
endmodule
`default_nettype wire

/* File: sim/sar_adc_channel_sequencer_tb.sv */
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: Zero wait state APB, tick every 6 pclk.
// Notes:   Scan, range, firmware, continuous and sleep cases.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_channel_sequencer_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} sas_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        deep_sleep = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, ana_cmp, ana_sample;
    wire  [2:0]  ana_chan;
    wire  [11:0] ana_dac;
    logic [95:0] level = {12'hF00, 12'h0F0, 12'h5A5, 12'h3C3,
                          12'hABC, 12'h789, 12'h456, 12'h123};
    logic [2:0]  visit [$];
    int          smp [8];
    int          slen = 0;
    int          cyc = 0;
    int          fails = 0;
    int          n_compared = 0;
    sas_row_t    rows [13] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'hFF, 1'b0},
        '{8'h08, 32'h0, 1'b0}, '{8'h0C, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b0},
        '{8'h14, 32'hFFF, 1'b0}, '{8'h18, 32'h0, 1'b0}, '{8'h20, 32'h3, 1'b0},
        '{8'h3C, 32'h3, 1'b0}, '{8'h40, 32'h0, 1'b0}, '{8'h5C, 32'h0, 1'b0},
        '{8'h60, 32'h0, 1'b1}, '{8'h1A, 32'h0, 1'b1}};
    sas_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .deep_sleep, .ana_cmp, .ana_chan,
        .ana_sample, .ana_dac);
    sas_analog_model u_ana (.level, .ana_chan, .ana_dac, .ana_cmp);
    // Clock
    always #5 pclk = ~pclk;
    // Channel order and sample window lengths
    always @(posedge pclk) begin
        cyc++;
        if (ana_sample === 1'b1) begin
            if (slen == 0) visit.push_back(ana_chan);
            slen++;
        end else if (slen != 0) begin
            smp[ana_chan] = slen;
            slen = 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, output logic [31:0] q);
        logic e;
        int   n;
        n = 0;
        q = 32'h0;
        while ((q & m) == 32'h0 && n < 400) begin
            apb(1'b0, a, 32'h0, q, e);
            n++;
        end
    endtask
    task automatic chk_irq(input logic x);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, x});
    endtask
    task automatic print_verdict;
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    // Main sequence
    initial begin
        logic [31:0] q;
        logic        e;
        int          n;
        int          t0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0, q, e);
            chk(q, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        apb(1'b1, 8'h60, 32'hFFFF, q, e);
        chk({31'h0, e}, 32'h1);
        // Scan of 0, 2, 5, 7 with sample windows of 3, 1, 10 and 1 ticks
        wr(8'h10, 32'h100);
        wr(8'h14, 32'hE00);
        wr(8'h04, 32'hA5);
        wr(8'h28, 32'h1);
        wr(8'h34, 32'hA);
        wr(8'h3C, 32'h0);
        wr(8'h00, 32'h1);
        t0 = cyc;
        wr(8'h00, 32'h9);
        poll(8'h08, 32'h1, q);
        chk(32'((cyc - t0) inside {[510:540]}), 32'h1);
        chk(visit.size(), 32'h4);
        chk({20'h0, visit[0], visit[1], visit[2], visit[3]}, 32'h0AF);
        chk(32'(smp[0] inside {[13:23]}), 32'h1);
        chk(32'(smp[2] inside {[1:11]}), 32'h1);
        chk(32'(smp[5] inside {[55:65]}), 32'h1);
        chk(32'(smp[7] inside {[1:11]}), 32'h1);
        rd(8'h40, 32'h80000123);
        rd(8'h48, 32'h80000789);
        rd(8'h54, 32'h800005A5);
        rd(8'h5C, 32'h80000F00);
        rd(8'h44, 32'h0);
        rd(8'h40, 32'h123);
        rd(8'h08, 32'h1F);
        chk_irq(1'b0);
        wr(8'h0C, 32'h2);
        chk_irq(1'b1);
        wr(8'h08, 32'h3);
        rd(8'h08, 32'h1C);
        chk_irq(1'b0);
        // Range event ahead of scan end
        wr(8'h10, 32'h200);
        wr(8'h04, 32'h81);
        wr(8'h00, 32'h9);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        rd(8'h08, 32'h02);
        poll(8'h08, 32'h1, q);
        wr(8'h08, 32'h3);
        // Firmware selected channel 3
        visit.delete();
        wr(8'h00, 32'h35);
        wr(8'h00, 32'h3D);
        poll(8'h4C, 32'h80000000, q);
        chk(q, 32'h80000ABC);
        chk(visit.size(), 32'h1);
        chk({29'h0, visit[0]}, 32'h3);
        rd(8'h08, 32'h1C);
        // Continuous scan wraps
        wr(8'h04, 32'h06);
        visit.delete();
        wr(8'h00, 32'h3);
        wr(8'h00, 32'hB);
        n = 0;
        while (visit.size() < 4 && n < 1200) begin
            @(posedge pclk);
            n++;
        end
        while (ana_sample === 1'b1) @(posedge pclk);
        wr(8'h00, 32'h0);
        chk({20'h0, visit[0], visit[1], visit[2], visit[3]}, 32'h28A);
        // Start refused in deep sleep
        deep_sleep <= 1'b1;
        repeat (8) @(posedge pclk);
        visit.delete();
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h9);
        repeat (300) @(posedge pclk);
        chk(visit.size(), 32'h0);
        deep_sleep <= 1'b0;
        // Reset while idle restores defaults
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'hFF);
        rd(8'h08, 32'h0);
        rd(8'h34, 32'h3);
        rd(8'h4C, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
